// file: rtl/swc_pkg.sv
// package for the sleep and wake controller: register map, field layout, reset values, timing.
// assumes a 40 MHz system clock that keeps running while the core oscillator driver is off.
`default_nettype none

package swc_pkg;

	// register byte offsets on the avalon slave
	localparam logic [3:0] REG_CTRL   = 4'h0;        // watchdog enable and prescaler control
	localparam logic [3:0] REG_STATUS = 4'h4;        // flags, state and wake cause
	localparam logic [3:0] REG_WDT    = 4'h8;        // live watchdog count

	// control register field positions
	localparam int CTRL_WDT_EN = 0;                  // watchdog enabled
	localparam int CTRL_PSA    = 1;                  // prescaler assigned to watchdog
	localparam int CTRL_PS_LO  = 2;                  // prescaler select, low bit
	localparam int CTRL_PS_HI  = 4;                  // prescaler select, high bit

	// status register field positions
	localparam int STAT_TO     = 0;                  // time_out_flag
	localparam int STAT_PD     = 1;                  // power_down_flag
	localparam int STAT_ST_LO  = 2;                  // fsm state, low bit
	localparam int STAT_ST_HI  = 3;                  // fsm state, high bit
	localparam int STAT_WK_LO  = 4;                  // last wake cause, low bit
	localparam int STAT_WK_HI  = 5;                  // last wake cause, high bit

	// reset values
	localparam logic [4:0]  CTRL_RESET = 5'h01;      // watchdog on, prescaler off, ratio 1:1
	localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

	// wake cause encoding
	typedef enum logic [1:0] {
		WAKE_NONE = 2'h0,
		WAKE_MASTER_CLEAR_PIN = 2'h1,
		WAKE_WDT  = 2'h2,
		WAKE_INT  = 2'h3
	} swc_wake_t;

	// power state, gray along run, sleep, start-up, resume
	typedef enum logic [1:0] {
		ST_RUN    = 2'h0,
		ST_SLEEP  = 2'h1,
		ST_OSCUP  = 2'h3,
		ST_RESUME = 2'h2
	} swc_state_t;

	// oscillator start-up wait before the core may run again
	localparam int SYS_CLK_KHZ     = 40000;
	localparam int OSC_START_NS    = 1000;
	localparam int OSC_START_CYC   = (OSC_START_NS * SYS_CLK_KHZ + 999999) / 1000000;

	// watchdog defaults
	localparam int WDT_COUNT_W     = 8;              // watchdog counter width
	localparam int WDT_TERMINAL    = 255;            // count at which the watchdog times out
	localparam int PRESC_W         = 7;              // prescaler up to 1:128

endpackage : swc_pkg

`default_nettype wire

// file: rtl/swc_sleep_wake_control.sv
// sleep entry and wake-up control of a small 8-bit core, with its watchdog and an avalon-mm slave.
// assumes core-side signals are on SYS_CLK, the watchdog rc tick and master clear come from pins.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`default_nettype none

module swc_sleep_wake_control #(
	parameter int N_INT      = 4,                       // number of interrupt sources
	parameter int IO_W       = 6,                       // number of i/o pins
	parameter int OSC_CYC    = swc_pkg::OSC_START_CYC,  // oscillator settle count
	parameter int WDT_END    = swc_pkg::WDT_TERMINAL    // watchdog time-out count
) (
	// clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  ARST_N,
	// avalon-mm slave
	input  wire logic [3:0]            AVS_ADDRESS,
	input  wire logic                  AVS_READ,
	input  wire logic                  AVS_WRITE,
	input  wire logic [31:0]           AVS_WRITEDATA,
	output logic      [31:0]           AVS_READDATA,
	output logic                       AVS_WAITREQUEST,
	// core instruction events
	input  wire logic                  SLEEP_EXEC,
	input  wire logic                  WDT_CLEAR_EXEC,
	input  wire logic [13:0]           NEXT_WORD,
	// interrupt enables and flags
	input  wire logic [N_INT-1:0]      INT_ENABLE,
	input  wire logic [N_INT-1:0]      INT_FLAG,
	input  wire logic                  GLOBAL_INT_ENABLE,
	// pins from outside the clock domain
	input  wire logic                  MASTER_CLEAR_PIN_N,
	input  wire logic                  WDT_RC_TICK,
	// core i/o drive before the pads
	input  wire logic [IO_W-1:0]       IO_DRIVE_IN,
	input  wire logic [IO_W-1:0]       IO_OE_IN,
	// pad drive
	output logic      [IO_W-1:0]       IO_DRIVE,
	output logic      [IO_W-1:0]       IO_OE,
	// core control
	output logic                       OSC_DRIVE_EN,
	output logic                       CORE_CLK_EN,
	output logic                       CORE_RESET,
	output logic      [13:0]           PREFETCH_WORD,
	output logic                       RESUME_EXEC,
	output logic                       VECTOR_REQ,
	// status
	output logic                       POWER_DOWN_FLAG,
	output logic                       TIME_OUT_FLAG
);

	// synchronisers: 3 stages, filtered level follows once stages 2 and 3 agree
	logic [2:0] master_clear_pin_sync_ff;                // master clear pin stages
	logic [2:0] tick_sync_ff;                // watchdog rc tick stages
	logic       master_clear_pin_lvl_ff;                 // filtered pin level
	logic       tick_lvl_ff;                 // filtered tick level
	logic       tick_prev_ff;                // for edge detect

	// state
	swc_pkg::swc_state_t state_ff;           // power state
	swc_pkg::swc_state_t nxt_state;          // next power state
	swc_pkg::swc_wake_t  wake_ff;            // last wake cause
	swc_pkg::swc_wake_t  nxt_wake;           // cause chosen this cycle
	logic [15:0]         osc_cnt_ff;         // oscillator settle counter
	logic                gie_wake_ff;        // vector wanted after resume
	logic                vector_ff;          // vector request pulse

	// flags, registers, outputs
	logic                      pd_ff;            // power_down_flag
	logic                      to_ff;            // time_out_flag
	logic [4:0]                ctrl_ff;          // control register
	logic [14-1:0]             prefetch_ff;      // kept instruction
	logic [IO_W-1:0]           io_drv_ff;        // pad drive level
	logic [IO_W-1:0]           io_oe_ff;         // pad enable
	logic                      core_rst_ff;      // core reset
	logic [swc_pkg::PRESC_W-1:0]     presc_ff;   // watchdog prescaler
	logic [swc_pkg::WDT_COUNT_W-1:0] wdt_ff;     // watchdog count
	logic                      ack_ff;           // bus answer cycle
	logic [31:0]               rdata_ff;         // read data

	// state compare, shared by the state decoders
	function automatic logic state_is(input swc_pkg::swc_state_t cur, input swc_pkg::swc_state_t want);
		return (cur == want);
	endfunction : state_is

	// decoding
	wire logic master_clear_pin_active = ~master_clear_pin_lvl_ff;                            // pin held low
	wire logic rc_edge     = tick_lvl_ff & ~tick_prev_ff;             // one rc period
	wire logic wdt_en      = ctrl_ff[swc_pkg::CTRL_WDT_EN];
	wire logic psa         = ctrl_ff[swc_pkg::CTRL_PSA];
	wire logic [2:0] ps_sel = ctrl_ff[swc_pkg::CTRL_PS_HI:swc_pkg::CTRL_PS_LO];
	wire logic int_hit     = |(INT_ENABLE & INT_FLAG);                // global enable not used
	wire logic in_run      = state_is(state_ff, swc_pkg::ST_RUN);
	wire logic in_sleep    = state_is(state_ff, swc_pkg::ST_SLEEP);
	wire logic in_oscup    = state_is(state_ff, swc_pkg::ST_OSCUP);     // waiting for a stable clock
	wire logic in_resume   = state_is(state_ff, swc_pkg::ST_RESUME);    // kept word runs this cycle
	wire logic sleep_go    = in_run & SLEEP_EXEC & ~master_clear_pin_active;

	// prescaler terminal: ratio 1:2^ps_sel when assigned, else every rc edge
	wire logic [swc_pkg::PRESC_W-1:0] presc_mask = swc_pkg::PRESC_W'((8'h01 << ps_sel) - 8'h01);
	wire logic presc_done  = ~psa | ((presc_ff & presc_mask) == presc_mask);
	wire logic wdt_step    = wdt_en & rc_edge & presc_done;
	wire logic wdt_fire    = wdt_step & (wdt_ff == swc_pkg::WDT_COUNT_W'(WDT_END));
	wire logic wdt_wake    = in_sleep & wdt_fire;                     // asleep: wake only
	wire logic wdt_reset   = ~in_sleep & wdt_fire;                    // awake: reset
	wire logic wake_req    = (in_sleep & (master_clear_pin_active | int_hit)) | wdt_wake;
	wire logic osc_done    = (osc_cnt_ff == 16'(OSC_CYC - 1));
	wire logic wdt_clr     = WDT_CLEAR_EXEC | sleep_go | wake_req;

	// bus decode
	wire logic bus_req     = AVS_READ | AVS_WRITE;
	wire logic wr_take     = AVS_WRITE & ack_ff;
	wire logic hit_ctrl    = (AVS_ADDRESS == swc_pkg::REG_CTRL);
	wire logic hit_stat    = (AVS_ADDRESS == swc_pkg::REG_STATUS);
	wire logic hit_wdt     = (AVS_ADDRESS == swc_pkg::REG_WDT);

	// status word
	wire logic [31:0] stat_word = {26'h0, wake_ff, state_ff, pd_ff, to_ff};

	// read mux, unmapped reads zero
	wire logic [31:0] rd_mux =
		hit_ctrl ? {27'h0, ctrl_ff} :
		hit_stat ? stat_word :
		hit_wdt  ? {{(32 - swc_pkg::WDT_COUNT_W){1'b0}}, wdt_ff} :
		swc_pkg::READ_ZERO;

	// wake cause priority: master clear, watchdog, interrupt
	always_comb begin
		nxt_wake = wake_ff;
		if (wake_req) begin
			if (master_clear_pin_active) begin
				nxt_wake = swc_pkg::WAKE_MASTER_CLEAR_PIN;
			end else if (wdt_fire) begin
				nxt_wake = swc_pkg::WAKE_WDT;
			end else begin
				nxt_wake = swc_pkg::WAKE_INT;
			end
		end
	end

	// power state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			swc_pkg::ST_RUN: begin
				if (sleep_go) begin
					nxt_state = swc_pkg::ST_SLEEP;
				end
			end
			swc_pkg::ST_SLEEP: begin
				if (wake_req) begin
					nxt_state = swc_pkg::ST_OSCUP;         // restart oscillator
				end
			end
			swc_pkg::ST_OSCUP: begin
				if (osc_done) begin
					// master clear: straight to run under reset
					nxt_state = (wake_ff == swc_pkg::WAKE_MASTER_CLEAR_PIN) ? swc_pkg::ST_RUN : swc_pkg::ST_RESUME;
				end
			end
			swc_pkg::ST_RESUME: begin
				nxt_state = swc_pkg::ST_RUN;
			end
			default: begin
				nxt_state = swc_pkg::ST_RUN;
			end
		endcase
	end

	// pin synchronisers, first stage read only by the second
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			master_clear_pin_sync_ff <= 3'h7;
			tick_sync_ff <= 3'h0;
		end else begin
			master_clear_pin_sync_ff <= {master_clear_pin_sync_ff[1:0], MASTER_CLEAR_PIN_N};
			tick_sync_ff <= {tick_sync_ff[1:0], WDT_RC_TICK};
		end
	end

	// filtered levels and tick edge
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			master_clear_pin_lvl_ff  <= 1'b1;
			tick_lvl_ff  <= 1'b0;
			tick_prev_ff <= 1'b0;
		end else begin
			if (master_clear_pin_sync_ff[1] == master_clear_pin_sync_ff[2]) begin
				master_clear_pin_lvl_ff <= master_clear_pin_sync_ff[2];
			end
			if (tick_sync_ff[1] == tick_sync_ff[2]) begin
				tick_lvl_ff <= tick_sync_ff[2];
			end
			tick_prev_ff <= tick_lvl_ff;
		end
	end

	// state, cause and oscillator settle counter
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_ff   <= swc_pkg::ST_RUN;
			wake_ff    <= swc_pkg::WAKE_NONE;
			osc_cnt_ff <= 16'h0000;
		end else begin
			state_ff   <= nxt_state;
			wake_ff    <= nxt_wake;
			// count only while waiting for a stable clock
			osc_cnt_ff <= in_oscup ? osc_cnt_ff + 16'h0001 : 16'h0000;
		end
	end

	// watchdog prescaler and counter
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			presc_ff <= '0;
			wdt_ff   <= '0;
		end else if (wdt_clr | wdt_fire) begin
			presc_ff <= '0;                              // prescaler cleared too
			wdt_ff   <= '0;                              // keeps counting after
		end else if (wdt_en & rc_edge) begin
			presc_ff <= presc_done ? '0 : presc_ff + 1'b1;
			wdt_ff   <= presc_done ? wdt_ff + 1'b1 : wdt_ff;
		end
	end

	// status flags, power-on values both set
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pd_ff <= 1'b1;
			to_ff <= 1'b1;
		end else begin
			if (sleep_go) begin
				pd_ff <= 1'b0;
				to_ff <= 1'b1;
			end
			if (wdt_fire) begin
				to_ff <= 1'b0;                           // also on awake time-out
			end
		end
	end

	// kept instruction, captured as sleep is taken
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prefetch_ff <= 14'h0000;
		end else if (sleep_go) begin
			prefetch_ff <= NEXT_WORD;
		end
	end

	// pad drive: follows the core while running, frozen otherwise
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			io_drv_ff <= '0;
			io_oe_ff  <= '0;
		end else if (in_run & ~sleep_go) begin
			io_drv_ff <= IO_DRIVE_IN;
			io_oe_ff  <= IO_OE_IN;
		end                                              // hold high, low or off
	end

	// internal core reset: pin level or awake watchdog time-out
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			core_rst_ff <= 1'b1;
		end else begin
			core_rst_ff <= (master_clear_pin_active & ~in_sleep) | wdt_reset |
				(in_oscup && wake_ff == swc_pkg::WAKE_MASTER_CLEAR_PIN);
		end
	end

	// vector request two cycles after the resume pulse
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gie_wake_ff <= 1'b0;
			vector_ff   <= 1'b0;
		end else begin
			if (in_resume) begin
				gie_wake_ff <= GLOBAL_INT_ENABLE & (wake_ff == swc_pkg::WAKE_INT);
			end else begin
				gie_wake_ff <= 1'b0;
			end
			vector_ff <= gie_wake_ff;                    // after the kept instruction
		end
	end

	// bus answer: one wait cycle, then the access completes
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_ff   <= 1'b0;
			rdata_ff <= swc_pkg::READ_ZERO;
		end else begin
			ack_ff   <= bus_req & ~ack_ff;
			rdata_ff <= (AVS_READ & ~ack_ff) ? rd_mux : rdata_ff;
		end
	end

	// control register write
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_ff <= swc_pkg::CTRL_RESET;
		end else if (wr_take & hit_ctrl) begin
			ctrl_ff <= AVS_WRITEDATA[4:0];
		end
	end

	// outputs
	assign AVS_WAITREQUEST = bus_req & ~ack_ff;
	assign AVS_READDATA    = rdata_ff;
	assign IO_DRIVE        = io_drv_ff;
	assign IO_OE           = io_oe_ff;
	assign OSC_DRIVE_EN    = ~in_sleep;
	assign CORE_CLK_EN     = in_run | in_resume;
	assign CORE_RESET      = core_rst_ff;
	assign PREFETCH_WORD   = prefetch_ff;
	assign RESUME_EXEC     = in_resume;
	assign VECTOR_REQ      = vector_ff;
	assign POWER_DOWN_FLAG = pd_ff;
	assign TIME_OUT_FLAG   = to_ff;

endmodule : swc_sleep_wake_control

`default_nettype wire

// file: bench/swc_chk.sv
// assertions on the sleep and wake controller ports.
// assumes one clock domain, reset asynchronous and active low.
`default_nettype none
module swc_chk #(
	parameter int N_INT   = 4,
	parameter int IO_W    = 6,
	parameter int OSC_CYC = 40
) (
	// clock and reset
	input wire logic             SYS_CLK,
	input wire logic             ARST_N,
	// core side inputs
	input wire logic             SLEEP_EXEC,
	input wire logic [13:0]      NEXT_WORD,
	input wire logic [N_INT-1:0] INT_ENABLE,
	input wire logic [N_INT-1:0] INT_FLAG,
	input wire logic             GLOBAL_INT_ENABLE,
	input wire logic             MASTER_CLEAR_PIN_N,
	// watched outputs
	input wire logic [IO_W-1:0]  IO_DRIVE,
	input wire logic [IO_W-1:0]  IO_OE,
	input wire logic             OSC_DRIVE_EN,
	input wire logic             CORE_CLK_EN,
	input wire logic             CORE_RESET,
	input wire logic [13:0]      PREFETCH_WORD,
	input wire logic             RESUME_EXEC,
	input wire logic             VECTOR_REQ,
	input wire logic             POWER_DOWN_FLAG
);
	timeunit 1ns;
	timeprecision 100ps;
	int osc_cnt_ff;  // cycles with oscillator on, core clock off
	int nxt_osc_cnt; // next settle count
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// count restarts once the core clock runs
	assign nxt_osc_cnt = (OSC_DRIVE_EN && !CORE_CLK_EN) ? osc_cnt_ff + 1 : 0;
	// settle counter register
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			osc_cnt_ff <= 0;
		end else begin
			osc_cnt_ff <= nxt_osc_cnt;
		end
	end
	sleep_entry_a: assert property (
		SLEEP_EXEC && CORE_CLK_EN && !RESUME_EXEC && !CORE_RESET && MASTER_CLEAR_PIN_N && $past(MASTER_CLEAR_PIN_N, 5)
		|=> !OSC_DRIVE_EN && !CORE_CLK_EN && !POWER_DOWN_FLAG && PREFETCH_WORD == $past(NEXT_WORD)) else $error("bad sleep entry");
	osc_settle_a: assert property ($rose(CORE_CLK_EN) |-> osc_cnt_ff == OSC_CYC)
		else $error("core clock before settle");
	io_hold_a: assert property (
		!CORE_CLK_EN && !$past(CORE_CLK_EN) |-> $stable(IO_DRIVE) && $stable(IO_OE)) else $error("pads moved asleep");
	pd_fall_a: assert property ($fell(POWER_DOWN_FLAG) |-> !OSC_DRIVE_EN && !CORE_CLK_EN)
		else $error("flag cleared outside sleep");
	pd_set_a: assert property (!$rose(POWER_DOWN_FLAG)) else $error("flag set after power-up");
	resume_pulse_a: assert property (
		RESUME_EXEC |-> !CORE_RESET ##1 !RESUME_EXEC && CORE_CLK_EN) else $error("bad resume pulse");
	vector_gate_a: assert property (
		VECTOR_REQ |-> $past(RESUME_EXEC, 2) && $past(GLOBAL_INT_ENABLE, 2)) else $error("stray vector");
	no_vector_a: assert property (RESUME_EXEC && !GLOBAL_INT_ENABLE |-> ##2 !VECTOR_REQ)
		else $error("vector without global enable");
	int_wake_a: assert property (
		!OSC_DRIVE_EN && (|(INT_ENABLE & INT_FLAG)) |=> OSC_DRIVE_EN && !CORE_CLK_EN) else $error("no wake");
	master_clear_pin_reset_a: assert property ($fell(MASTER_CLEAR_PIN_N) && !OSC_DRIVE_EN |-> ##[1:20] CORE_RESET)
		else $error("no reset on master clear");
endmodule : swc_chk
bind swc_sleep_wake_control swc_chk #(.N_INT(N_INT), .IO_W(IO_W), .OSC_CYC(OSC_CYC)) swc_chk_i (
	.SYS_CLK, .ARST_N, .SLEEP_EXEC, .NEXT_WORD, .INT_ENABLE, .INT_FLAG, .GLOBAL_INT_ENABLE,
	.MASTER_CLEAR_PIN_N, .IO_DRIVE, .IO_OE, .OSC_DRIVE_EN, .CORE_CLK_EN, .CORE_RESET,
	.PREFETCH_WORD, .RESUME_EXEC, .VECTOR_REQ, .POWER_DOWN_FLAG);
`default_nettype wire

// file: bench/swc_core_model.sv
// far-side model: core pad drive and the watchdog rc oscillator.
// assumes clk is the system clock; the rc clock stands still while off.
`default_nettype none
module swc_core_model (
	// from the bench
	input wire logic   clk,
	input wire logic   tick_on,
	// to the controller
	output logic       rc_tick,
	output logic [5:0] io_drive,
	output logic [5:0] io_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	int div; // half period counter
	// start quiet
	initial begin
		rc_tick = 1'b0;
		io_drive = 6'h00;
		io_oe = 6'h00;
		div = 0;
	end
	// rc clock, half period 16 cycles, low while off
	always @(posedge clk) begin
		if (!tick_on) begin
			div <= 0;
			rc_tick <= 1'b0;
		end else if (div == 15) begin
			div <= 0;
			rc_tick <= !rc_tick;
		end else begin
			div <= div + 1;
		end
	end
	// pads change every cycle so a frozen output shows
	always @(posedge clk) begin
		io_drive <= io_drive + 6'h05;
		io_oe <= io_oe ^ 6'h2B;
	end
endmodule : swc_core_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the sleep and wake controller.
// assumes package, controller, checker and core model compiled first.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OSC = 6; // shortened settle count
	logic        SYS_CLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, tick_on;
	logic [3:0]  AVS_ADDRESS, INT_ENABLE, INT_FLAG;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
	logic        SLEEP_EXEC, WDT_CLEAR_EXEC, GLOBAL_INT_ENABLE, MASTER_CLEAR_PIN_N, WDT_RC_TICK;
	logic [13:0] NEXT_WORD, PREFETCH_WORD;
	logic [5:0]  IO_DRIVE_IN, IO_OE_IN, IO_DRIVE, IO_OE;
	logic [11:0] io_snap;        // pad enable and level frozen at sleep
	logic        OSC_DRIVE_EN, CORE_CLK_EN, CORE_RESET, RESUME_EXEC, VECTOR_REQ, POWER_DOWN_FLAG, TIME_OUT_FLAG;
	logic        exp_pd, exp_to; // model flags
	logic [13:0] words[$];       // model: words kept over sleep
	int          fails, compares;
	int          seed = 32'h35EAAD4C;
	swc_sleep_wake_control #(.OSC_CYC(OSC), .WDT_END(3)) swc_sleep_wake_control_i (.SYS_CLK, .ARST_N,
		.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .SLEEP_EXEC,
		.WDT_CLEAR_EXEC, .NEXT_WORD, .INT_ENABLE, .INT_FLAG, .GLOBAL_INT_ENABLE, .MASTER_CLEAR_PIN_N,
		.WDT_RC_TICK, .IO_DRIVE_IN, .IO_OE_IN, .IO_DRIVE, .IO_OE, .OSC_DRIVE_EN, .CORE_CLK_EN, .CORE_RESET,
		.PREFETCH_WORD, .RESUME_EXEC, .VECTOR_REQ, .POWER_DOWN_FLAG, .TIME_OUT_FLAG);
	swc_core_model swc_core_model_i (.clk(SYS_CLK), .tick_on, .rc_tick(WDT_RC_TICK), .io_drive(IO_DRIVE_IN),
		.io_oe(IO_OE_IN));
	always #12.5 SYS_CLK = !SYS_CLK;
	// status word from model flags
	function automatic logic [31:0] st(input logic [1:0] cause);
		return {26'h0, cause, 2'h0, exp_pd, exp_to};
	endfunction : st
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// one avalon transfer held until waitrequest is sampled low at a rising edge
	// outputs are read before that edge's non-blocking updates land
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= wd;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		@(posedge SYS_CLK);
		while (AVS_WAITREQUEST !== 1'b0) begin
			n++;
			@(posedge SYS_CLK);
		end
		rd = AVS_READDATA;
		chk(n, 1); // one wait cycle per access
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge SYS_CLK);
	endtask : bus
	// bounded wait, ends at the negedge where s is high
	task automatic wait_hi(ref logic s, input int lim);
		@(negedge SYS_CLK);
		for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge SYS_CLK);
		chk(s, 1);
	endtask : wait_hi
	// sleep instruction with a random next word
	task automatic do_sleep;
		NEXT_WORD <= 14'($random(seed));
		SLEEP_EXEC <= 1'b1;
		@(posedge SYS_CLK);
		SLEEP_EXEC <= 1'b0;
		words.push_back(NEXT_WORD);
		exp_pd = 1'b0;
		exp_to = 1'b1;
		@(negedge SYS_CLK);
		io_snap = {IO_OE, IO_DRIVE};
		chk(POWER_DOWN_FLAG, exp_pd);
		chk(TIME_OUT_FLAG, exp_to);
		chk(CORE_CLK_EN, 0);
		@(posedge SYS_CLK);
	endtask : do_sleep
	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// hang guard
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		fails++;
		report_and_stop();
	end
	// main sequence
	initial begin
		{SYS_CLK, ARST_N, AVS_READ, AVS_WRITE, SLEEP_EXEC, WDT_CLEAR_EXEC, GLOBAL_INT_ENABLE, tick_on} = 8'h00;
		{AVS_ADDRESS, AVS_WRITEDATA, NEXT_WORD, INT_ENABLE, INT_FLAG} = 58'h0;
		MASTER_CLEAR_PIN_N = 1'b1;
		fails = 0;
		compares = 0;
		exp_pd = 1'b1;
		exp_to = 1'b1;
		repeat (8) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		@(posedge SYS_CLK);
		bus(0, swc_pkg::REG_CTRL, 0);
		chk(rd, {27'h0, swc_pkg::CTRL_RESET});
		bus(1, swc_pkg::REG_STATUS, 32'hFFFFFFFF);
		bus(1, 4'hC, 32'hFFFFFFFF);
		bus(0, 4'hC, 0);
		chk(rd, 0);
		bus(0, swc_pkg::REG_STATUS, 0);
		chk(rd, st(0));
		bus(1, swc_pkg::REG_CTRL, 0);
		// every source, global enable off then on
		for (int s = 0; s < 8; s++) begin
			INT_ENABLE <= 4'h1 << s[1:0];
			GLOBAL_INT_ENABLE <= s[2];
			@(posedge SYS_CLK);
			do_sleep();
			INT_FLAG <= ~(4'h1 << s[1:0]);
			repeat (5) @(negedge SYS_CLK);
			chk(OSC_DRIVE_EN, 0);
			chk({IO_OE, IO_DRIVE}, io_snap);
			@(posedge SYS_CLK);
			INT_FLAG <= 4'hF;
			wait_hi(RESUME_EXEC, OSC + 8);
			chk(PREFETCH_WORD, words.pop_front());
			repeat (2) @(negedge SYS_CLK);
			chk(VECTOR_REQ, s[2]);
			@(posedge SYS_CLK);
			INT_FLAG <= 4'h0;
			bus(0, swc_pkg::REG_STATUS, 0);
			chk(rd, st(3));
		end
		// pending source wakes at once
		INT_ENABLE <= 4'h4;
		INT_FLAG <= 4'h4;
		GLOBAL_INT_ENABLE <= 1'b0;
		@(posedge SYS_CLK);
		do_sleep();
		wait_hi(RESUME_EXEC, OSC + 3);
		chk(PREFETCH_WORD, words.pop_front());
		@(posedge SYS_CLK);
		INT_FLAG <= 4'h0;
		// watchdog on with prescaler 1:2: two rc periods give one step
		bus(1, swc_pkg::REG_CTRL, 32'h7);
		tick_on <= 1'b1;
		repeat (70) @(posedge SYS_CLK);
		tick_on <= 1'b0;
		bus(0, swc_pkg::REG_WDT, 0);
		chk(rd, 1);
		WDT_CLEAR_EXEC <= 1'b1;
		@(posedge SYS_CLK);
		WDT_CLEAR_EXEC <= 1'b0;
		bus(0, swc_pkg::REG_WDT, 0);
		chk(rd, 0);
		bus(1, swc_pkg::REG_CTRL, 32'h1);
		// time-out while running
		tick_on <= 1'b1;
		wait_hi(CORE_RESET, 300);
		exp_to = 1'b0;
		@(negedge SYS_CLK);
		chk(CORE_RESET, 0);
		@(posedge SYS_CLK);
		tick_on <= 1'b0;
		bus(0, swc_pkg::REG_STATUS, 0);
		chk(rd & 32'h3, st(0));
		// time-out while asleep only wakes
		tick_on <= 1'b1;
		repeat (24) @(posedge SYS_CLK);
		do_sleep();
		bus(0, swc_pkg::REG_WDT, 0);
		chk(rd, 0);
		wait_hi(RESUME_EXEC, 300);
		chk(CORE_RESET, 0);
		exp_to = 1'b0;
		@(posedge SYS_CLK);
		tick_on <= 1'b0;
		bus(0, swc_pkg::REG_STATUS, 0);
		chk(rd, st(2));
		bus(0, swc_pkg::REG_WDT, 0);
		chk(rd, 0);
		// master clear while asleep
		do_sleep();
		MASTER_CLEAR_PIN_N <= 1'b0;
		wait_hi(CORE_RESET, OSC + 12);
		chk(OSC_DRIVE_EN, 1);
		repeat (OSC + 6) @(negedge SYS_CLK);
		chk(CORE_RESET, 1);
		@(posedge SYS_CLK);
		MASTER_CLEAR_PIN_N <= 1'b1;
		repeat (8) @(negedge SYS_CLK);
		chk(CORE_RESET, 0);
		@(posedge SYS_CLK);
		bus(0, swc_pkg::REG_STATUS, 0);
		chk(rd, st(1));
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
